// [psb_pkg.sv]
package psb_pkg;
  localparam int NUM_OUT = 6;
  localparam int NUM_CCP = 4;
  localparam int NUM_CMP = 4;
  localparam int SRC_W = 4;
  localparam int NUM_ASD_SRC = 8;
  // modulation source encodings
  localparam logic [3:0] MSRC_SOFT = 4'h0;
  localparam logic [3:0] MSRC_PIN = 4'h1;
  localparam logic [3:0] MSRC_CCP0 = 4'h2;
  localparam logic [3:0] MSRC_CMP0 = 4'h6;
  localparam logic [3:0] MSRC_LAST = 4'ha;
  // reset values
  localparam logic [5:0] STEER_RST = 6'h00;
  localparam logic [5:0] LEVELS_RST = 6'h00;
  localparam logic [5:0] IDLE_RST = 6'h00;

  typedef enum logic [1:0] {
    PSB_MODE_SINGLE,
    PSB_MODE_COMPL,
    PSB_MODE_3PHASE,
    PSB_MODE_FIXED
  } psb_mode_t;

  typedef struct packed {
    logic module_enable_bit;
    logic buffer_load_request;
    logic steer_sync_enable;
    logic [5:0] steering_select_reg;
  } psb_steer_ctl_t;

  typedef struct packed {
    logic modulation_enable_bit;
    logic software_modulation_bit;
    logic [3:0] source;
  } psb_mdl_ctl_t;

  typedef struct packed {
    logic shutdown_enable_bit;
    logic override_force_bit;
    logic auto_restart_select;
    logic [7:0] shutdown_source_select;
    logic [5:0] shutdown_output_levels;
  } psb_asd_ctl_t;
endpackage : psb_pkg

// [psb_sync2.sv]
`timescale 1ns/1ps
`default_nettype none
module psb_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : psb_sync2
`default_nettype wire

// [psb_steer_burst_shutdown.sv]
`timescale 1ns/1ps
`default_nettype none
module psb_steer_burst_shutdown
  import psb_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // waveform core
  input wire logic PERIOD_EVENT,
  input wire logic [psb_pkg::NUM_OUT-1:0] PWM_RAW,
  input wire logic [psb_pkg::NUM_OUT-1:0] IDLE_LEVELS,
  input wire psb_pkg::psb_mode_t MODE,
  output logic RUN,
  output logic PERIOD_RESTART,
  // steering control
  input wire psb_pkg::psb_steer_ctl_t STEER_CTL,
  output logic LOAD_PENDING,
  output logic [psb_pkg::NUM_OUT-1:0] STEER_ACTIVE,
  // modulation
  input wire psb_pkg::psb_mdl_ctl_t MDL_CTL,
  input wire logic EXT_EVENT_PIN,
  input wire logic [psb_pkg::NUM_CCP-1:0] CCP_OUT,
  input wire logic [psb_pkg::NUM_CMP-1:0] CMP_OUT,
  // shutdown
  input wire psb_pkg::psb_asd_ctl_t ASD_CTL,
  input wire logic [psb_pkg::NUM_ASD_SRC-1:0] ASD_SRC,
  input wire logic EVENT_FLAG_SET,
  input wire logic EVENT_FLAG_CLR,
  output logic SHUTDOWN_EVENT_FLAG,
  output logic SHUTDOWN_ACTIVE,
  output logic ASD_IRQ,
  // pins
  output logic [psb_pkg::NUM_OUT-1:0] PWM_OUT
);
  // asynchronous sources pass two flops first
  logic pin_s;
  logic [NUM_CCP-1:0] ccp_s;
  logic [NUM_CMP-1:0] cmp_s;
  logic [NUM_ASD_SRC-1:0] asd_s;

  psb_sync2 #(.W(1 + NUM_CCP + NUM_CMP + NUM_ASD_SRC)) u_sync (
    .clk(CLK),
    .rst(RST),
    .d({EXT_EVENT_PIN, CCP_OUT, CMP_OUT, ASD_SRC}),
    .q({pin_s, ccp_s, cmp_s, asd_s})
  );

  // steering buffer and load request
  logic en_d;
  logic ld_d;
  logic ssync_d;
  logic load_pend;
  logic [NUM_OUT-1:0] steer_buf;
  logic [NUM_OUT-1:0] steer_held;
  logic en_rise;
  logic ld_rise;

  assign en_rise = STEER_CTL.module_enable_bit & ~en_d;
  assign ld_rise = STEER_CTL.buffer_load_request & ~ld_d;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      en_d <= 1'b0;
      ld_d <= 1'b0;
      ssync_d <= 1'b0;
    end else begin
      en_d <= STEER_CTL.module_enable_bit;
      ld_d <= STEER_CTL.buffer_load_request;
      ssync_d <= STEER_CTL.steer_sync_enable;
    end
  end

  // the buffer snapshot is taken on the set, independent of sync mode
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      steer_buf <= STEER_RST;
    end else if (en_rise || ld_rise || !STEER_CTL.module_enable_bit) begin
      steer_buf <= STEER_CTL.steering_select_reg;
    end
  end

  // pending load survives until a period event or module disable; set wins over done
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      load_pend <= 1'b0;
    end else if (ld_rise) begin
      load_pend <= 1'b1;
    end else if (PERIOD_EVENT || !STEER_CTL.module_enable_bit) begin
      load_pend <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      steer_held <= STEER_RST;
    end else if (!STEER_CTL.module_enable_bit) begin
      steer_held <= STEER_CTL.steering_select_reg;
    end else if (STEER_CTL.steer_sync_enable && !ssync_d) begin
      steer_held <= steer_buf;
    end else if (load_pend && PERIOD_EVENT) begin
      steer_held <= steer_buf;
    end
  end

  // fixed duty mode steers straight from the select register; sync only in the other modes
  logic steer_sync_on;
  logic [NUM_OUT-1:0] steer_eff;
  assign steer_sync_on = STEER_CTL.steer_sync_enable &&
                         (MODE != PSB_MODE_FIXED);
  assign steer_eff = steer_sync_on ? steer_held
                                   : STEER_CTL.steering_select_reg;

  // modulation source mux: one source at a time by encoding
  logic mdl_src;
  always_comb begin
    mdl_src = MDL_CTL.software_modulation_bit;
    if (MDL_CTL.source == MSRC_PIN) begin
      mdl_src = pin_s;
    end else if (MDL_CTL.source >= MSRC_CCP0 &&
                 MDL_CTL.source < MSRC_CMP0) begin
      mdl_src = ccp_s[2'(MDL_CTL.source - MSRC_CCP0)];
    end else if (MDL_CTL.source >= MSRC_CMP0 &&
                 MDL_CTL.source < MSRC_LAST) begin
      mdl_src = cmp_s[2'(MDL_CTL.source - MSRC_CMP0)];
    end
  end

  logic mdl_req;
  assign mdl_req = MDL_CTL.modulation_enable_bit ? mdl_src : 1'b1;

  // shutdown flags
  logic asd_hit;
  logic asd_cond;
  logic restart_wait;
  logic soft_evt;
  logic flag_drop;
  assign asd_hit = |(asd_s & ASD_CTL.shutdown_source_select);
  // a source-raised flag lets go by itself under auto restart, otherwise
  // the pins could never come back; a software-raised one waits for a clear
  assign flag_drop = EVENT_FLAG_CLR ||
                     (ASD_CTL.auto_restart_select && !soft_evt);
  assign asd_cond = asd_hit || (SHUTDOWN_EVENT_FLAG && !flag_drop);

  // remembers that software, not a source, raised the flag
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      soft_evt <= 1'b0;
    end else if (!ASD_CTL.shutdown_enable_bit) begin
      soft_evt <= 1'b0;
    end else if (EVENT_FLAG_SET) begin
      soft_evt <= 1'b1;
    end else if (EVENT_FLAG_CLR) begin
      soft_evt <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SHUTDOWN_EVENT_FLAG <= 1'b0;
    end else if (!ASD_CTL.shutdown_enable_bit) begin
      SHUTDOWN_EVENT_FLAG <= 1'b0;
    end else if (asd_hit || EVENT_FLAG_SET) begin
      SHUTDOWN_EVENT_FLAG <= 1'b1;
    end else if (flag_drop) begin
      SHUTDOWN_EVENT_FLAG <= 1'b0;
    end
  end

  // interrupt pulse only from the flag rising; the force bit never raises it
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ASD_IRQ <= 1'b0;
    end else begin
      ASD_IRQ <= ASD_CTL.shutdown_enable_bit && !SHUTDOWN_EVENT_FLAG &&
                 (asd_hit || EVENT_FLAG_SET);
    end
  end

  // active flag: manual clear needs software; auto clears with condition
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SHUTDOWN_ACTIVE <= 1'b0;
    end else if (!ASD_CTL.shutdown_enable_bit) begin
      SHUTDOWN_ACTIVE <= 1'b0;
    end else if (asd_cond || EVENT_FLAG_SET) begin
      SHUTDOWN_ACTIVE <= 1'b1;
    end else if (ASD_CTL.auto_restart_select || EVENT_FLAG_CLR) begin
      SHUTDOWN_ACTIVE <= 1'b0;
    end
  end

  // outputs stay overridden until the next period event after release
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      restart_wait <= 1'b0;
    end else if (SHUTDOWN_ACTIVE) begin
      restart_wait <= 1'b1;
    end else if (PERIOD_EVENT) begin
      restart_wait <= 1'b0;
    end
  end

  // burst state machine
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_DRAIN
  } psb_burst_t;
  psb_burst_t state;
  psb_burst_t next_state;
  logic fixed_inactive;
  // in fixed duty the period event toggles phase; freeze on the one
  // that leaves the pwm inactive, i.e. when the raw pwm is active now
  assign fixed_inactive = |PWM_RAW;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (mdl_req && STEER_CTL.module_enable_bit) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!STEER_CTL.module_enable_bit) begin
          next_state = ST_IDLE;
        end else if (!mdl_req) begin
          next_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (!STEER_CTL.module_enable_bit) begin
          next_state = ST_IDLE;
        end else if (PERIOD_EVENT) begin
          if (MODE != PSB_MODE_FIXED || fixed_inactive) begin
            next_state = ST_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RUN <= 1'b0;
      PERIOD_RESTART <= 1'b0;
      LOAD_PENDING <= 1'b0;
      STEER_ACTIVE <= STEER_RST;
    end else begin
      RUN <= (next_state != ST_IDLE);
      PERIOD_RESTART <= (state == ST_IDLE) && (next_state == ST_RUN);
      LOAD_PENDING <= load_pend;
      STEER_ACTIVE <= steer_eff;
    end
  end

  // output stage: override first, then burst idle, then steered pwm
  logic override_on;
  assign override_on = ASD_CTL.shutdown_enable_bit &&
                       (SHUTDOWN_ACTIVE || SHUTDOWN_EVENT_FLAG ||
                        restart_wait || ASD_CTL.override_force_bit);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_pin
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          PWM_OUT[gi] <= LEVELS_RST[gi];
        end else if (override_on) begin
          PWM_OUT[gi] <= ASD_CTL.shutdown_output_levels[gi];
        end else if (state == ST_IDLE || !steer_eff[gi]) begin
          PWM_OUT[gi] <= IDLE_LEVELS[gi];
        end else begin
          PWM_OUT[gi] <= PWM_RAW[gi];
        end
      end
    end
  endgenerate
endmodule : psb_steer_burst_shutdown
`default_nettype wire

// [psb_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module psb_sva
  import psb_pkg::*;
(
  // watched ports
  input wire logic CLK,
  input wire logic RST,
  input wire logic PERIOD_EVENT,
  input wire psb_pkg::psb_mode_t MODE,
  input wire psb_pkg::psb_steer_ctl_t STEER_CTL,
  input wire psb_pkg::psb_asd_ctl_t ASD_CTL,
  input wire logic [psb_pkg::NUM_ASD_SRC-1:0] ASD_SRC,
  input wire logic PERIOD_RESTART,
  input wire logic LOAD_PENDING,
  input wire logic [psb_pkg::NUM_OUT-1:0] STEER_ACTIVE,
  input wire logic SHUTDOWN_EVENT_FLAG,
  input wire logic ASD_IRQ,
  input wire logic SHUTDOWN_ACTIVE,
  input wire logic [psb_pkg::NUM_OUT-1:0] PWM_OUT
);
  logic en, hot, ss, me, ld, fo;
  logic [5:0] lv;
  assign en = ASD_CTL.shutdown_enable_bit;
  assign hot = en && |(ASD_SRC & ASD_CTL.shutdown_source_select);
  assign lv = ASD_CTL.shutdown_output_levels;
  assign fo = ASD_CTL.override_force_bit;
  assign ss = STEER_CTL.steer_sync_enable;
  assign me = STEER_CTL.module_enable_bit;
  assign ld = STEER_CTL.buffer_load_request;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_irq_single: assert property (ASD_IRQ |=> !ASD_IRQ)
    else $error("irq held");
  a_asd_idle: assert property (!en && !$past(en) |->
    !SHUTDOWN_ACTIVE && !SHUTDOWN_EVENT_FLAG && !ASD_IRQ)
    else $error("shutdown while disabled");
  a_src_flag: assert property (hot [*4] |-> SHUTDOWN_EVENT_FLAG)
    else $error("source did not set flag");
  a_shut_pins: assert property (SHUTDOWN_EVENT_FLAG && en &&
    $past(SHUTDOWN_EVENT_FLAG) && $past(en) && $stable(lv) |-> PWM_OUT == lv)
    else $error("shutdown pins wrong");
  a_force_pins: assert property (en && fo && $past(fo) &&
    $past(en) && !$past(RST) && $stable(lv) |-> PWM_OUT == lv)
    else $error("forced pins wrong");
  a_load_seen: assert property ($rose(ld) && me &&
    !PERIOD_EVENT |-> ##2 LOAD_PENDING)
    else $error("load not pending");
  a_load_done: assert property (LOAD_PENDING && PERIOD_EVENT |->
    ##[1:2] !LOAD_PENDING)
    else $error("load not cleared");
  // a select write without a load must not leak through mid-period
  a_steer_hold: assert property (ss && $past(ss) && $past(ss, 2) &&
    me && $past(me) && !$rose(ld) && !LOAD_PENDING &&
    !$past(LOAD_PENDING) &&
    !$past(LOAD_PENDING, 2) && $stable(MODE) && !$past(RST)
    |=> $stable(STEER_ACTIVE))
    else $error("steering changed unloaded");
  c_irq: cover property (ASD_IRQ);
  c_restart: cover property (PERIOD_RESTART);
  c_load: cover property (LOAD_PENDING && PERIOD_EVENT);
endmodule : psb_sva
`default_nettype wire

// [psb_fault_model.sv]
`timescale 1ns/1ps
`default_nettype none
module psb_fault_model (
  // command
  input wire logic CLK,
  input wire logic fault,
  input wire logic [2:0] idx,
  input wire logic [1:0] lag,
  // sense lines
  output logic [7:0] asd_src
);
  logic [3:0] hist = 4'h0;
  // a slow sensor reports late; healthy lines are driven low
  always @(posedge CLK) begin
    hist <= {hist[2:0], fault};
    asd_src <= hist[lag] ? 8'h01 << idx : 8'h00;
  end
endmodule : psb_fault_model
`default_nettype wire

// [psb_steer_burst_shutdown_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module psb_steer_burst_shutdown_tb;
  import psb_pkg::*;
  logic CLK = 0, RST = 1, PERIOD_EVENT = 0, EXT_EVENT_PIN = 0, fault = 0;
  logic EVENT_FLAG_SET = 0, EVENT_FLAG_CLR = 0, RUN, PERIOD_RESTART;
  logic LOAD_PENDING, SHUTDOWN_EVENT_FLAG, SHUTDOWN_ACTIVE, ASD_IRQ;
  logic [5:0] PWM_RAW = 0, IDLE_LEVELS = 0, STEER_ACTIVE, PWM_OUT, a, lv;
  logic [3:0] CCP_OUT = 0, CMP_OUT = 0;
  logic [7:0] ASD_SRC;
  logic [2:0] idx = 0, pc = 0;
  logic [1:0] lag = 0;
  psb_mode_t MODE = PSB_MODE_SINGLE;
  psb_steer_ctl_t STEER_CTL = '0;
  psb_mdl_ctl_t MDL_CTL = '0;
  psb_asd_ctl_t ASD_CTL = '0;
  integer seed = 43053, mismatches = 0, total_checks = 0, irqs = 0, i;
  integer rsts = 0;
  psb_steer_burst_shutdown uut (.*);
  psb_fault_model far (.CLK(CLK), .fault(fault), .idx(idx), .lag(lag),
    .asd_src(ASD_SRC));
  always #2.5 CLK = ~CLK;
  always @(posedge CLK) irqs <= irqs + (ASD_IRQ === 1'b1);
  always @(posedge CLK) rsts <= rsts + (PERIOD_RESTART === 1'b1);
  // waveform core stand-in: period event every 8 cycles
  always @(negedge CLK) begin
    pc <= pc + 3'h1;
    PERIOD_EVENT <= (pc == 3'h7);
    PWM_RAW <= 6'($random(seed));
  end
  task automatic chk(string n, logic [5:0] e, logic [5:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // steered pins follow the raw pwm, unsteered ones sit at idle level
  function automatic logic [5:0] pins_exp(logic [5:0] steer);
    return (PWM_RAW & steer) | (IDLE_LEVELS & ~steer);
  endfunction : pins_exp
  task automatic cyc(int n);
    repeat (n) @(negedge CLK);
  endtask : cyc
  task automatic report_and_stop;
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic clr;
    EVENT_FLAG_CLR = 1;
    cyc(1);
    EVENT_FLAG_CLR = 0;
    cyc(2);
  endtask : clr
  initial begin
    IDLE_LEVELS = 6'($random(seed));
    cyc(12);
    RST = 0;
    a = 6'($random(seed)) | 6'h01;
    STEER_CTL.steering_select_reg = a;
    STEER_CTL.module_enable_bit = 1;
    cyc(3);
    STEER_CTL.steer_sync_enable = 1;
    cyc(2);
    chk("steer_now", a, STEER_ACTIVE);
    STEER_CTL.steering_select_reg = ~a;
    cyc(20);
    chk("steer_held", a, STEER_ACTIVE);
    while (pc != 3'h2) cyc(1);
    STEER_CTL.buffer_load_request = 1;
    cyc(2);
    chk("load_wait", 6'h01, 6'(LOAD_PENDING));
    cyc(11);
    chk("steer_new", ~a, STEER_ACTIVE);
    chk("load_done", 6'h00, 6'(LOAD_PENDING));
    // every source code gates the burst in turn
    MDL_CTL.modulation_enable_bit = 1;
    for (i = 0; i < 10; i++) begin
      MODE = psb_mode_t'(2'(i));
      MDL_CTL.source = 4'(i);
      {CMP_OUT, CCP_OUT, EXT_EVENT_PIN, MDL_CTL.software_modulation_bit} =
        10'h000;
      cyc(24);
      chk("run_off", 6'h00, 6'(RUN));
      chk("idle_pins", IDLE_LEVELS, PWM_OUT);
      {CMP_OUT, CCP_OUT, EXT_EVENT_PIN, MDL_CTL.software_modulation_bit} =
        10'h001 << i;
      cyc(24);
      chk("run_on", 6'h01, 6'(RUN));
    end
    MDL_CTL = '0;
    MODE = PSB_MODE_SINGLE;
    cyc(24);
    chk("run_free", 6'h01, 6'(RUN));
    // one start after reset plus one per modulation source
    chk("restarts", 6'h0b, 6'(rsts));
    ASD_CTL.shutdown_enable_bit = 1;
    for (i = 0; i < 4; i++) begin
      lv = 6'($random(seed));
      ASD_CTL.shutdown_output_levels = lv;
      ASD_CTL.override_force_bit = 1;
      cyc(3);
      chk("force_pins", lv, PWM_OUT);
      ASD_CTL.override_force_bit = 0;
      idx = 3'($random(seed));
      lag = 2'(i);
      ASD_CTL.shutdown_source_select = 8'h01 << idx;
      ASD_CTL.auto_restart_select = i[0];
      fault = 1;
      cyc(10);
      chk("flag", 6'h01, 6'(SHUTDOWN_EVENT_FLAG));
      chk("asd_pins", lv, PWM_OUT);
      clr();
      chk("clr_refused", 6'h01, 6'(SHUTDOWN_ACTIVE));
      fault = 0;
      cyc(10);
      // manual restart holds the flag, auto restart drops it with the source
      chk("hold", {5'h00, ~i[0]}, 6'(SHUTDOWN_ACTIVE));
      clr();
      chk("cleared", 6'h00, 6'(SHUTDOWN_ACTIVE));
      cyc(12);
      chk("resumed", 6'h01, 6'(RUN));
      chk("resumed_pins", pins_exp(~a), PWM_OUT);
    end
    chk("irq_count", 6'h04, 6'(irqs));
    EVENT_FLAG_SET = 1;
    cyc(1);
    EVENT_FLAG_SET = 0;
    cyc(3);
    chk("soft_pins", lv, PWM_OUT);
    ASD_CTL.shutdown_enable_bit = 0;
    fault = 1;
    cyc(10);
    chk("asd_off", 6'h00, 6'(SHUTDOWN_EVENT_FLAG));
    report_and_stop();
  end
  initial begin
    cyc(4000);
    mismatches++;
    report_and_stop();
  end
endmodule : psb_steer_burst_shutdown_tb
bind psb_steer_burst_shutdown psb_sva chk_i (.*);
`default_nettype wire
